// ---- hw/pts_top.sv ----
// Two-wire command decoder for slot transfers, wiper stepping and deferred programming
// Function
// - Frame S, address, 1110 slot pot instruction, acks, P copies wiper into slot.
// - Frame S, address, 1101 slot pot instruction, wiper loads from slot as the ack begins, then P.
// - Instruction 001000 pot then direction bits without ack, ended by STOP.
// - Slot programming begins only after STOP, not at data acceptance.
// - Address byte 0101 plus four straps is acknowledged only on match.
// - Each step clock moves wiper up with data high below FF, down with data low above 00.
// - Wiper to slot copy is a non-volatile write lasting at least write cycle time.
`timescale 1ns/100ps
`include "pts_consts.svh"
module pts_top #(
    parameter int WR_CYCLES = `PTS_WR_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Address straps
    input wire logic [3:0] addr_strap,
    // Live wiper settings, pot 0 in the low byte
    output logic [31:0] live_wiper_setting,
    // Programming in progress
    output logic nv_busy
);
    localparam int NUM_POTS = 4;
    localparam int CW = $clog2(WR_CYCLES + 1);

    // Input synchronisers and edge history
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    logic [3:0] strap_m_q, strap_s_q;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            strap_m_q <= 4'h0;
            strap_s_q <= 4'h0;
        end
        else
        begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            strap_m_q <= addr_strap;
            strap_s_q <= strap_m_q;
        end
    end

    logic rise, fall, start_det, stop_det;
    assign rise = scl_s_q && !scl_p_q;
    assign fall = !scl_s_q && scl_p_q;
    assign start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
    assign stop_det = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

    // Protocol state
    pts_pkg::pts_state_t state_q, state_d, after_q, after_d;
    logic [3:0] bitcnt_q, bitcnt_d;
    logic [7:0] shift_q, shift_d;
    logic oe_q, oe_d;
    logic pend_q, pend_d;
    logic [3:0] pend_addr_q, pend_addr_d;
    logic [7:0] pend_data_q, pend_data_d;
    logic busy_q, busy_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic rd_en_q, rd_en_d, rd_pend_q;
    logic [3:0] rd_addr_q, rd_addr_d;
    logic [1:0] sel_q, sel_d;
    logic dir_q, dir_d, armed_q, armed_d, fire_q, fire_d;
    logic mem_we;
    logic [7:0] mem_rdata;
    logic [7:0] wip_q [NUM_POTS];
    logic addr_ok, is_w2s, is_s2w, is_step;
    logic [1:0] f_pot, f_slot;

    assign addr_ok = (shift_q == {`PTS_ADDR_HI, strap_s_q}) && !busy_q;
    assign is_w2s = shift_q[7:4] == `PTS_OP_W2S;
    assign is_s2w = shift_q[7:4] == `PTS_OP_S2W;
    assign is_step = shift_q[7:2] == `PTS_OP_STEP;
    assign f_pot = shift_q[`PTS_POT_MSB:`PTS_POT_LSB];
    assign f_slot = shift_q[`PTS_SLOT_MSB:`PTS_SLOT_LSB];

    always_comb
    begin
        state_d = state_q;
        after_d = after_q;
        bitcnt_d = bitcnt_q;
        shift_d = shift_q;
        oe_d = oe_q;
        pend_d = pend_q;
        pend_addr_d = pend_addr_q;
        pend_data_d = pend_data_q;
        busy_d = busy_q;
        cnt_d = cnt_q;
        rd_en_d = 1'b0;
        rd_addr_d = rd_addr_q;
        sel_d = sel_q;
        dir_d = dir_q;
        armed_d = armed_q;
        fire_d = 1'b0;
        mem_we = 1'b0;
        if (busy_q)
        begin
            if (cnt_q == '0)
            begin
                busy_d = 1'b0;
            end
            else
            begin
                cnt_d = cnt_q - 1'b1;
            end
        end
        if (start_det)
        begin
            state_d = pts_pkg::ST_ADDR;
            bitcnt_d = 4'h0;
            oe_d = 1'b0;
            armed_d = 1'b0;
        end
        else if (stop_det)
        begin
            state_d = pts_pkg::ST_IDLE;
            oe_d = 1'b0;
            armed_d = 1'b0;
            if (pend_q)
            begin
                mem_we = 1'b1;
                pend_d = 1'b0;
                busy_d = 1'b1;
                cnt_d = CW'(WR_CYCLES - 1);
            end
        end
        else
        begin
            case (state_q)
                pts_pkg::ST_ADDR, pts_pkg::ST_INSTR:
                begin
                    if (rise)
                    begin
                        shift_d = {shift_q[6:0], sda_s_q};
                        bitcnt_d = bitcnt_q + 4'h1;
                    end
                    else if (fall && bitcnt_q == 4'h8)
                    begin
                        state_d = pts_pkg::ST_IDLE;
                        if (state_q == pts_pkg::ST_ADDR)
                        begin
                            if (addr_ok)
                            begin
                                oe_d = 1'b1;
                                state_d = pts_pkg::ST_ACK;
                                after_d = pts_pkg::ST_INSTR;
                            end
                        end
                        else if (is_w2s || is_s2w || is_step)
                        begin
                            oe_d = 1'b1;
                            state_d = pts_pkg::ST_ACK;
                            after_d = pts_pkg::ST_WAIT;
                            sel_d = f_pot;
                            if (is_w2s)
                            begin
                                pend_d = 1'b1;
                                pend_addr_d = {f_pot, f_slot};
                                pend_data_d = wip_q[f_pot];
                            end
                            if (is_s2w)
                            begin
                                rd_en_d = 1'b1;
                                rd_addr_d = {f_pot, f_slot};
                            end
                            if (is_step)
                            begin
                                after_d = pts_pkg::ST_STEP;
                            end
                        end
                    end
                end
                pts_pkg::ST_ACK:
                begin
                    if (fall)
                    begin
                        oe_d = 1'b0;
                        state_d = after_q;
                        bitcnt_d = 4'h0;
                    end
                end
                pts_pkg::ST_STEP:
                begin
                    // sample direction, step at pulse end
                    if (rise)
                    begin
                        dir_d = sda_s_q;
                        armed_d = 1'b1;
                    end
                    else if (fall && armed_q)
                    begin
                        fire_d = 1'b1;
                        armed_d = 1'b0;
                    end
                end
                default:
                begin
                    state_d = state_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= pts_pkg::ST_IDLE;
            after_q <= pts_pkg::ST_IDLE;
            bitcnt_q <= 4'h0;
            shift_q <= 8'h00;
            oe_q <= 1'b0;
            pend_q <= 1'b0;
            pend_addr_q <= 4'h0;
            pend_data_q <= 8'h00;
            busy_q <= 1'b0;
            cnt_q <= '0;
            rd_en_q <= 1'b0;
            rd_pend_q <= 1'b0;
            rd_addr_q <= 4'h0;
            sel_q <= 2'h0;
            dir_q <= 1'b0;
            armed_q <= 1'b0;
            fire_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            after_q <= after_d;
            bitcnt_q <= bitcnt_d;
            shift_q <= shift_d;
            oe_q <= oe_d;
            pend_q <= pend_d;
            pend_addr_q <= pend_addr_d;
            pend_data_q <= pend_data_d;
            busy_q <= busy_d;
            cnt_q <= cnt_d;
            rd_en_q <= rd_en_d;
            rd_pend_q <= rd_en_q;
            rd_addr_q <= rd_addr_d;
            sel_q <= sel_d;
            dir_q <= dir_d;
            armed_q <= armed_d;
            fire_q <= fire_d;
        end
    end

    pts_mem #(.AW(4), .DW(8)) u_slots (
        .clk(clk),
        .we(mem_we),
        .waddr(pend_addr_q),
        .wdata(pend_data_q),
        .re(rd_en_q),
        .raddr(rd_addr_q),
        .rdata_q(mem_rdata)
    );

    // Per-pot live wiper setting
    for (genvar i = 0; i < NUM_POTS; i++)
    begin : g_pot
        logic [7:0] wip_d;
        always_comb
        begin
            wip_d = wip_q[i];
            if (rd_pend_q && sel_q == 2'(i))
            begin
                wip_d = mem_rdata;
            end
            else if (fire_q && sel_q == 2'(i))
            begin
                if (dir_q && wip_q[i] != `PTS_WIPER_MAX)
                begin
                    wip_d = wip_q[i] + 8'h01;
                end
                else if (!dir_q && wip_q[i] != `PTS_WIPER_RST)
                begin
                    wip_d = wip_q[i] - 8'h01;
                end
            end
        end
        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                wip_q[i] <= `PTS_WIPER_RST;
            end
            else
            begin
                wip_q[i] <= wip_d;
            end
        end
        assign live_wiper_setting[i*8 +: 8] = wip_q[i];
    end

    assign sda_o = 1'b0;
    assign sda_oe = oe_q;
    assign nv_busy = busy_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic addr_ack_ev, instr_ack_ev;
    assign addr_ack_ev = !start_det && !stop_det && fall && bitcnt_q == 4'h8 && state_q == pts_pkg::ST_ADDR;
    assign instr_ack_ev = !start_det && !stop_det && fall && bitcnt_q == 4'h8 && state_q == pts_pkg::ST_INSTR;
    sequence s_load;
        rd_en_q ##1 rd_pend_q;
    endsequence

    a_addr_ack_match: assert property (addr_ack_ev |=> oe_q == $past(addr_ok))
        else $error("address ack does not follow match");
    a_w2s_capture: assert property (instr_ack_ev && is_w2s |=> pend_q && oe_q && pend_data_q == $past(wip_q[f_pot]))
        else $error("wiper copy not captured");
    a_s2w_load: assert property (instr_ack_ev && is_s2w |=> s_load ##1 wip_q[sel_q] == $past(mem_rdata))
        else $error("slot not loaded into wiper");
    a_step_noack: assert property (state_q == pts_pkg::ST_STEP |-> !oe_q)
        else $error("ack driven during stepping");
    a_nv_after_stop: assert property ($rose(busy_q) |-> $past(stop_det) && $past(pend_q) && !pend_q)
        else $error("programming started without stop");
    a_busy_hold: assert property ($rose(busy_q) |-> busy_q[*8])
        else $error("programming cycle too short");
    a_step_up: assert property (fire_q && dir_q && wip_q[sel_q] != 8'hFF |=> wip_q[$past(sel_q)] == $past(wip_q[sel_q]) + 8'h01)
        else $error("wiper did not step up");
    a_step_down: assert property (fire_q && !dir_q && wip_q[sel_q] != 8'h00 |=> wip_q[$past(sel_q)] == $past(wip_q[sel_q]) - 8'h01)
        else $error("wiper did not step down");
endmodule

// ---- hw/pts_consts.svh ----
// Constants for the pot transfer and stepping command decoder
`ifndef PTS_CONSTS_SVH
`define PTS_CONSTS_SVH
// Address byte upper nibble
`define PTS_ADDR_HI 4'h5
// Instruction codes
`define PTS_OP_W2S 4'hE
`define PTS_OP_S2W 4'hD
`define PTS_OP_STEP 6'h08
// Instruction field positions
`define PTS_SLOT_MSB 3
`define PTS_SLOT_LSB 2
`define PTS_POT_MSB 1
`define PTS_POT_LSB 0
// Wiper reset value and upper step limit
`define PTS_WIPER_RST 8'h00
`define PTS_WIPER_MAX 8'hFF
// Non-volatile write cycle time and clock period
`define PTS_T_WR_NS 5000000
`define PTS_CLK_NS 10
`define PTS_WR_CYC ((`PTS_T_WR_NS + `PTS_CLK_NS - 1) / `PTS_CLK_NS)
`endif

// ---- hw/pts_pkg.sv ----
// Types for the pot transfer and stepping command decoder
package pts_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_INSTR, ST_ACK, ST_STEP, ST_WAIT} pts_state_t;
endpackage

// ---- hw/pts_mem.sv ----
// Stored setting slot memory with registered read data
`timescale 1ns/100ps
module pts_mem #(
    parameter int AW = 4,
    parameter int DW = 8
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // Read port
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_q
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        if (re)
        begin
            rdata_q <= mem[raddr];
        end
    end
endmodule

// ---- verif/pts_host.sv ----
// Two-wire bus master model that frames commands for the decoder
`timescale 1ns/100ps
module pts_host (
    // Bus wires, a released data line reads high
    output logic scl,
    output logic sda_rel,
    input wire logic sda_line
);
    localparam realtime Q = 31.25;
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic start();
        sda_rel = 1'b1;
        scl = 1'b1;
        #Q;
        sda_rel = 1'b0;
        #Q;
        scl = 1'b0;
    endtask
    // Data set while clock low, sampled at mid high
    task automatic bit_io(input logic v, output logic got);
        #Q;
        sda_rel = v;
        #Q;
        scl = 1'b1;
        #Q;
        got = sda_line;
        #Q;
        scl = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], g);
        bit_io(1'b1, g);
        ack = ~g;
    endtask
    task automatic stop();
        #Q;
        sda_rel = 1'b0;
        #Q;
        scl = 1'b1;
        #Q;
        sda_rel = 1'b1;
        #(2*Q);
    endtask
endmodule

// ---- verif/test_pot_transfer_stepping_commands.sv ----
// Self-checking bench for the pot transfer and stepping decoder
`timescale 1ns/100ps
module test_pot_transfer_stepping_commands;
    localparam int WR = 20;
    logic clk;
    logic rst_n;
    logic scl;
    logic sda_rel;
    logic sda_line;
    logic sda_o;
    logic sda_oe;
    logic [3:0] strap;
    logic [31:0] wipers;
    logic nv_busy;
    logic ack;
    int num_errors;
    int comparisons;
    int seed;
    int mw[4];
    int ms[16];
    int p;
    int s;
    int busy_run;
    assign sda_line = sda_rel & (sda_oe ? sda_o : 1'b1);
    pts_top #(.WR_CYCLES(WR)) uut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_strap(strap), .live_wiper_setting(wipers), .nv_busy(nv_busy));
    pts_host host (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Length of the current busy run, sampled away from the launching edge
    always @(negedge clk)
        busy_run <= (nv_busy === 1'b1) ? busy_run + 1 : 0;
    task automatic wrap_up();
        if (num_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_wipers();
        for (int i = 0; i < 4; i++)
        begin
            comparisons++;
            if (wipers[8*i +: 8] !== 8'(mw[i]))
            begin
                num_errors++;
                $display("CHECK FAILED at %0t: wiper %0d is %h expected %h", $time, i, wipers[8*i +: 8], mw[i]);
            end
        end
    endtask
    task automatic settle();
        repeat (10) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [3:0] a, input logic [7:0] ins, input logic ea, input logic ei);
        host.start();
        host.send_byte({4'h5, a}, ack);
        chk_bit(ack, ea);
        host.send_byte(ins, ack);
        chk_bit(ack, ei);
    endtask
    task automatic do_step(input int pp, input int n, input logic [31:0] dirs);
        logic g;
        cmd(strap, {6'h08, 2'(pp)}, 1'b1, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            host.bit_io(dirs[i], g);
            mw[pp] = dirs[i] ? ((mw[pp] < 255) ? mw[pp] + 1 : 255) : ((mw[pp] > 0) ? mw[pp] - 1 : 0);
        end
        host.stop();
        settle();
        chk_wipers();
    endtask
    task automatic copy(input int pp, input int ss);
        int n;
        cmd(strap, {4'hE, 2'(ss), 2'(pp)}, 1'b1, 1'b1);
        settle();
        chk_bit(nv_busy, 1'b0);
        host.stop();
        ms[4*pp+ss] = mw[pp];
        n = 0;
        while (nv_busy !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_bit(nv_busy, 1'b1);
        n = 0;
        while (nv_busy === 1'b1 && n < 1000)
        begin
            @(posedge clk);
            #1;
            n = busy_run;
        end
        chk_bit(n >= WR && n < 1000, 1'b1);
    endtask
    task automatic load(input int pp, input int ss);
        cmd(strap, {4'hD, 2'(ss), 2'(pp)}, 1'b1, 1'b1);
        host.stop();
        mw[pp] = ms[4*pp+ss];
        settle();
        chk_wipers();
    endtask
    initial
    begin
        #600000;
        num_errors++;
        wrap_up();
    end
    initial
    begin
        seed = 73;
        num_errors = 0;
        comparisons = 0;
        rst_n = 1'b0;
        strap = 4'h0;
        mw = '{default: 0};
        ms = '{default: 0};
        repeat (5) @(posedge clk);
        strap <= 4'($random(seed));
        rst_n <= 1'b1;
        settle();
        chk_bit(sda_oe, 1'b0);
        chk_bit(nv_busy, 1'b0);
        chk_wipers();
        for (int k = 0; k < 4; k++)
        begin
            cmd(strap ^ (4'h1 << k), 8'hE0, 1'b0, 1'b0);
            host.stop();
            settle();
            chk_bit(nv_busy, 1'b0);
        end
        host.start();
        host.send_byte({4'hD, strap}, ack);
        chk_bit(ack, 1'b0);
        host.stop();
        settle();
        cmd(strap, 8'h24, 1'b1, 1'b0);
        host.stop();
        cmd(strap, 8'hA1, 1'b1, 1'b0);
        host.stop();
        do_step(0, 4, 32'h0);
        for (int r = 0; r < 8; r++)
        begin
            p = $random(seed) & 3;
            s = $random(seed) & 3;
            do_step(p, 1 + ($random(seed) & 15), 32'($random(seed)));
            copy(p, s);
            do_step(p, 1 + ($random(seed) & 15), 32'($random(seed)));
            load(p, s);
        end
        repeat (9) do_step(1, 32, 32'hFFFFFFFF);
        wrap_up();
    end
endmodule
